// >>> logic/ipr_map.svh
// Purpose: Register indices, field positions, reset values and sizes of the priority interrupt controller.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH

`define IPR_NSRC          7
`define IPR_NINT          3
`define IPR_NEXT          4
`define IPR_AW            12

// Register indices.
`define IPR_IDX_CTRL      10'h000
`define IPR_IDX_GATE      10'h001
`define IPR_IDX_INSERV    10'h002
`define IPR_IDX_REQST     10'h003
`define IPR_IDX_MASK      10'h004
`define IPR_IDX_POLL      10'h005
`define IPR_IDX_SRC0      10'h010
`define IPR_IDX_RELOC     10'h0FE

// Source control fields.
`define IPR_F_RANK_LSB    0
`define IPR_F_BLOCK       3
`define IPR_F_LEVEL       4
`define IPR_F_CASC        5
`define IPR_F_SNEST       6

// Other fields.
`define IPR_F_POLL_MODE   0
`define IPR_F_SLAVE       14
`define IPR_F_POLL_VALID  15

// Reset values.
`define IPR_RST_RANK      3'h7
`define IPR_RST_GATE      3'h7
`define IPR_RST_RELOC     16'h0000
`define IPR_RST_CTRL      1'h0

// AXI responses.
`define IPR_RESP_OKAY     2'h0
`define IPR_RESP_SLVERR   2'h2

`endif

// >>> logic/ipr_pkg.sv
// Purpose: Types shared by the priority interrupt controller files.
// Assumes: ipr_map.svh is on the include path.
// Notes:   Constants live in the header, types live here.
`default_nettype none
`include "ipr_map.svh"

package ipr_pkg;

  typedef logic [2:0] ipr_rank_t;

  typedef struct packed {
    logic      special_nest_select;
    logic      cascade_select;
    logic      level_sense_select;
    logic      source_block_bit;
    ipr_rank_t urgency_rank;
  } ipr_cfg_s;

  typedef struct packed {
    logic [`IPR_NINT-1:0] req;
    logic [`IPR_NINT-1:0] en;
  } ipr_int_src_s;

  typedef struct packed {
    logic      valid;
    logic      cascade;
    logic [2:0] id;
  } ipr_grant_s;

endpackage : ipr_pkg
`default_nettype wire

// >>> logic/ipr_src.sv
// Purpose: One interrupt source channel: its control bits, pending latch and in-service bit.
// Assumes: req_in is already in the aclk domain.
// Notes:   A new request in the cycle of its clear keeps the pending bit set.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_map.svh"

module ipr_src (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             wr_ctl,
  input  wire logic             wr_block,
  input  wire logic [7:0]       wdata,
  input  wire logic             req_in,
  input  wire logic             take,
  input  wire logic             clr_isr,
  output var  ipr_pkg::ipr_cfg_s cfg,
  output logic                  pending,
  output logic                  in_service
);
  import ipr_pkg::*;

  ipr_cfg_s cfg_q;
  logic     req_prev_q;
  logic     pend_q;
  logic     isr_q;
  wire      rise = req_in & ~req_prev_q;
  wire      pend_set = cfg_q.level_sense_select ? req_in : rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.special_nest_select <= 1'b0;
      cfg_q.urgency_rank        <= `IPR_RST_RANK;
      cfg_q.level_sense_select  <= 1'b0;
      cfg_q.source_block_bit    <= 1'b1;
      cfg_q.cascade_select      <= 1'b0;
    end else if (wr_ctl) begin
      cfg_q.urgency_rank        <= wdata[`IPR_F_RANK_LSB +: 3];
      cfg_q.source_block_bit    <= wdata[`IPR_F_BLOCK];
      cfg_q.level_sense_select  <= wdata[`IPR_F_LEVEL];
      cfg_q.cascade_select      <= wdata[`IPR_F_CASC];
      cfg_q.special_nest_select <= wdata[`IPR_F_SNEST];
    end else if (wr_block) begin
      cfg_q.source_block_bit    <= wdata[0];
    end
  end

  // Edge mode latches a rising request; level mode follows the input.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_prev_q <= 1'b0;
      pend_q     <= 1'b0;
      isr_q      <= 1'b0;
    end else begin
      req_prev_q <= req_in;
      if (pend_set)
        pend_q <= 1'b1;
      else if (take || cfg_q.level_sense_select)
        pend_q <= 1'b0;
      if (take)
        isr_q <= 1'b1;
      else if (clr_isr)
        isr_q <= 1'b0;
    end
  end

  assign cfg        = cfg_q;
  assign pending    = pend_q;
  assign in_service = isr_q;

endmodule : ipr_src
`default_nettype wire

// >>> logic/ipr_top.sv
// Purpose: Priority interrupt controller with an AXI4-Lite register slave.
// Assumes: aclk 200 MHz; int_src and intr_ack come from aclk logic; ext_int pins are asynchronous.
// Notes:   Registers are 16 bits wide in the low half of each 32-bit word.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_map.svh"

module ipr_top (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`IPR_AW-1:0]     s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`IPR_AW-1:0]     s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire ipr_pkg::ipr_int_src_s  int_src,
  input  wire logic [`IPR_NEXT-1:0]   ext_int,
  input  wire logic                   intr_ack,
  output logic                        intr_req,
  output logic [2:0]                  intr_id,
  output logic                        cascade_ack,
  output logic                        slave_mode
);
  import ipr_pkg::*;

  localparam int NS = `IPR_NSRC;

  logic [`IPR_NEXT-1:0] ext_s1_q;
  logic [`IPR_NEXT-1:0] ext_s2_q;
  logic                 poll_mode_q;
  ipr_rank_t            gate_q;
  logic [15:0]          reloc_q;
  ipr_grant_s           grant_q;
  logic                 cascade_ack_q;
  logic                 awready_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 arready_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;

  ipr_cfg_s             cfg [NS];
  logic [NS-1:0]        pend;
  logic [NS-1:0]        isr;
  logic [NS-1:0]        req_vec;
  logic [NS-1:0]        cand;
  logic [NS-1:0]        take;
  logic [NS-1:0]        wr_ctl;

  // Pin inputs pass two flip-flops before any logic reads them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
    end else begin
      ext_s1_q <= ext_int;
      ext_s2_q <= ext_s1_q;
    end
  end

  wire slave = reloc_q[`IPR_F_SLAVE];

  // Slave mode serves only the internal sources; the pins belong to the master.
  assign req_vec = {ext_s2_q & {`IPR_NEXT{~slave}}, int_src.req & int_src.en};

  // Write channel: both address and data are taken in the same cycle.
  wire                 wr_go  = awready_q & s_axi_awvalid & s_axi_wvalid;
  wire [9:0]           widx   = s_axi_awaddr[11:2];
  wire [9:0]           wsrc   = widx - `IPR_IDX_SRC0;
  wire                 w_src  = (widx >= `IPR_IDX_SRC0) && (wsrc < 10'(NS));
  wire                 w_hit  = w_src || widx <= `IPR_IDX_POLL || widx == `IPR_IDX_RELOC;
  wire                 wb0    = wr_go & s_axi_wstrb[0];
  wire                 wb1    = wr_go & s_axi_wstrb[1];
  wire                 wr_blk = wb0 && widx == `IPR_IDX_MASK;
  wire                 eoi    = wb0 && widx == `IPR_IDX_INSERV;
  wire [7:0]           wd0    = s_axi_wdata[7:0];

  // Source channels.
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_src
      assign wr_ctl[g] = wb0 && w_src && wsrc == 10'(g);
      assign take[g]   = intr_ack && grant_q.valid && grant_q.id == 3'(g);
      ipr_src u_src (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .wr_ctl     (wr_ctl[g]),
        .wr_block   (wr_blk),
        .wdata      (wr_blk ? {7'h00, wd0[g]} : wd0),
        .req_in     (req_vec[g]),
        .take       (take[g]),
        .clr_isr    (eoi & wd0[g]),
        .cfg        (cfg[g]),
        .pending    (pend[g]),
        .in_service (isr[g])
      );
    end
  endgenerate

  // Most urgent in-service level, then the most urgent eligible request.
  ipr_rank_t isr_min;
  logic      isr_any;
  logic      best_ok;
  logic [2:0] best_id;
  ipr_rank_t best_rank;
  always_comb begin
    isr_min   = 3'h7;
    isr_any   = 1'b0;
    best_ok   = 1'b0;
    best_id   = 3'h0;
    best_rank = 3'h7;
    for (int i = 0; i < NS; i++) begin
      if (isr[i] && (!isr_any || cfg[i].urgency_rank < isr_min)) begin
        isr_min = cfg[i].urgency_rank;
        isr_any = 1'b1;
      end
    end
    for (int i = 0; i < NS; i++) begin
      cand[i] = pend[i] && !cfg[i].source_block_bit
             && cfg[i].urgency_rank <= gate_q
             && (!isr_any || cfg[i].urgency_rank < isr_min
                 || (cfg[i].special_nest_select && cfg[i].urgency_rank == isr_min));
      if (cand[i] && (!best_ok || cfg[i].urgency_rank < best_rank)) begin
        best_ok   = 1'b1;
        best_id   = 3'(i);
        best_rank = cfg[i].urgency_rank;
      end
    end
  end

  // The grant is reloaded with the current winner every cycle; an acknowledge takes it and the next winner follows a cycle later.
  wire ack_now = intr_ack & grant_q.valid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_q       <= '0;
      cascade_ack_q <= 1'b0;
    end else begin
      cascade_ack_q <= ack_now & grant_q.cascade & ~slave;
      if (ack_now)
        grant_q.valid <= 1'b0;
      else begin
        grant_q.valid   <= best_ok;
        grant_q.id      <= best_id;
        grant_q.cascade <= cfg[best_id].cascade_select;
      end
    end
  end

  // Control, level gate and relocation registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_mode_q <= `IPR_RST_CTRL;
      gate_q      <= `IPR_RST_GATE;
      reloc_q     <= `IPR_RST_RELOC;
    end else begin
      if (wb0 && widx == `IPR_IDX_CTRL)
        poll_mode_q <= wd0[`IPR_F_POLL_MODE];
      if (wb0 && widx == `IPR_IDX_GATE)
        gate_q <= wd0[2:0];
      if (wb0 && widx == `IPR_IDX_RELOC)
        reloc_q[7:0] <= wd0;
      if (wb1 && widx == `IPR_IDX_RELOC)
        reloc_q[15:8] <= s_axi_wdata[15:8];
    end
  end

  // Write handshake: ready for one cycle, response one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `IPR_RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= w_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
      end else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read decode.
  wire [9:0]  ridx  = s_axi_araddr[11:2];
  wire [9:0]  rsrc  = ridx - `IPR_IDX_SRC0;
  wire        r_src = (ridx >= `IPR_IDX_SRC0) && (rsrc < 10'(NS));
  wire        r_hit = r_src || ridx <= `IPR_IDX_POLL || ridx == `IPR_IDX_RELOC;
  wire        rd_go = arready_q & s_axi_arvalid;
  logic [15:0] rmux;
  logic [NS-1:0] blk_vec;
  always_comb begin
    for (int i = 0; i < NS; i++)
      blk_vec[i] = cfg[i].source_block_bit;
  end
  wire [15:0] poll_word = {grant_q.valid, 12'h000, grant_q.id};
  wire [15:0] src_word  = r_src ? {9'h000, cfg[rsrc[2:0]]} : 16'h0000;
  assign rmux = (ridx == `IPR_IDX_CTRL)   ? {15'h0000, poll_mode_q} :
                (ridx == `IPR_IDX_GATE)   ? {13'h0000, gate_q} :
                (ridx == `IPR_IDX_INSERV) ? {9'h000, isr} :
                (ridx == `IPR_IDX_REQST)  ? {9'h000, pend} :
                (ridx == `IPR_IDX_MASK)   ? {9'h000, blk_vec} :
                (ridx == `IPR_IDX_POLL)   ? poll_word :
                (ridx == `IPR_IDX_RELOC)  ? reloc_q : src_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `IPR_RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {16'h0000, r_hit ? rmux : 16'h0000};
        rresp_q  <= r_hit ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
      end else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // Core request line; in poll mode software reads the winner instead.
  logic intr_req_q;
  logic [2:0] intr_id_q;
  logic slave_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intr_req_q <= 1'b0;
      intr_id_q  <= 3'h0;
      slave_q    <= 1'b0;
    end else begin
      intr_req_q <= best_ok & ~poll_mode_q & ~ack_now;
      intr_id_q  <= best_id;
      slave_q    <= slave;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign intr_req      = intr_req_q;
  assign intr_id       = intr_id_q;
  assign cascade_ack   = cascade_ack_q;
  assign slave_mode    = slave_q;

endmodule : ipr_top
`default_nettype wire

// >>> verification/ipr_top_chk.sv
// Purpose: Port-level assertions for the priority interrupt controller.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every ipr_top instance.
`timescale 1ns/1ps
`default_nettype none

module ipr_top_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        intr_ack,
  input wire logic        intr_req,
  input wire logic        cascade_ack,
  input wire logic        slave_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RST_QUIET: assert property ($rose(aresetn) |-> !intr_req && !slave_mode && !cascade_ack)
    else $error("outputs not idle after reset");
  AST_MASKED_START: assert property ($rose(aresetn) |-> !intr_req [*3])
    else $error("request while all sources masked");
  AST_ONE_AT_A_TIME: assert property (intr_req && intr_ack |=> !intr_req)
    else $error("request held after acknowledge");
  AST_WR_PAIR: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
    else $error("write handshake not a joint pulse");
  AST_WR_RESP: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_RESP: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_SLAVE_CASC: assert property (slave_mode |-> !cascade_ack)
    else $error("cascade pulse in slave mode");

  COV_WR: cover property (s_axi_awready);
  COV_ACK: cover property (intr_req && intr_ack);
  COV_SLAVE: cover property (slave_mode);
endmodule : ipr_top_chk

bind ipr_top ipr_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .intr_ack(intr_ack),
  .intr_req(intr_req), .cascade_ack(cascade_ack), .slave_mode(slave_mode));

`default_nettype wire

// >>> verification/ipr_core_model.sv
// Purpose: Processor core that services requests from the interrupt controller.
// Assumes: Acknowledge is a one-cycle pulse on aclk.
// Notes:   Waits delay cycles, then acknowledges once per request.
`timescale 1ns/1ps
`default_nettype none

module ipr_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       intr_req,
  input  wire logic [2:0] intr_id,
  input  wire logic [3:0] delay,
  output logic            intr_ack,
  output logic [2:0]      last_id,
  output logic [7:0]      ack_cnt
);
  logic [3:0] wait_q;
  logic       done_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intr_ack <= 1'b0;
      wait_q   <= 4'h0;
      done_q   <= 1'b0;
      last_id  <= 3'h0;
      ack_cnt  <= 8'h00;
    end else begin
      intr_ack <= 1'b0;
      if (!intr_req) begin
        done_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (!done_q && wait_q == delay) begin
        // A second pulse for one request would be taken as a fresh acknowledge.
        intr_ack <= 1'b1;
        done_q   <= 1'b1;
        last_id  <= intr_id;
        ack_cnt  <= ack_cnt + 8'h01;
      end else if (!done_q) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : ipr_core_model

`default_nettype wire

// >>> verification/ipr_top_tb.sv
// Purpose: Self-checking bench for the priority interrupt controller.
// Assumes: Register byte address is four times the index.
// Notes:   Drives AXI4-Lite and pins; a core model answers requests.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_map.svh"

module ipr_top_tb;
  import ipr_pkg::*;
  localparam logic [9:0] IDX_TAB [6] = '{`IPR_IDX_CTRL, `IPR_IDX_GATE, `IPR_IDX_INSERV,
                                         `IPR_IDX_REQST, `IPR_IDX_MASK, `IPR_IDX_RELOC};
  localparam logic [31:0] EXP_TAB [6] = '{32'h0, 32'h7, 32'h0, 32'h0, 32'h7F, 32'h0};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, intr_ack, intr_req, cascade_ack, slave_mode;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, ext_int, dly;
  logic [1:0] bresp, rresp, r, b;
  logic [2:0] intr_id, last_id;
  logic [7:0] ack_cnt;
  ipr_int_src_s int_src;
  int err_total, tests_run, casc_cnt;

  ipr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .int_src(int_src),
    .ext_int(ext_int), .intr_ack(intr_ack), .intr_req(intr_req), .intr_id(intr_id),
    .cascade_ack(cascade_ack), .slave_mode(slave_mode));
  ipr_core_model u_core (.aclk(aclk), .aresetn(aresetn), .intr_req(intr_req), .intr_id(intr_id),
    .delay(dly), .intr_ack(intr_ack), .last_id(last_id), .ack_cnt(ack_cnt));

  // Counts cascade pulses, which last a single cycle.
  always @(posedge aclk) begin
    if (cascade_ack === 1'b1) begin
      casc_cnt <= casc_cnt + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] idx, input logic [15:0] v);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    b = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic wait_acks(input logic [7:0] n);
    do @(posedge aclk); while (ack_cnt !== n);
  endtask : wait_acks

  task automatic chk_rst();
    for (int i = 0; i < 7; i++) begin
      rd(`IPR_IDX_SRC0 + 10'(i));
      chk(d, 32'h0000000F);
    end
    for (int i = 0; i < 6; i++) begin
      rd(IDX_TAB[i]);
      chk(d, EXP_TAB[i]);
    end
    chk(slave_mode, 32'h0);
  endtask : chk_rst

  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ext_int, int_src} = '0;
    wstrb = 4'h3;
    dly = 4'h2;
    err_total = 0;
    tests_run = 0;
    casc_cnt = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rst();
    rd(10'h006);
    chk({d[31:2], r}, 32'h2);
    wr(10'h006, 16'hFFFF);
    chk(b, 32'h2);
    wr(`IPR_IDX_SRC0 + 10'h3, 16'h0002);
    wr(`IPR_IDX_SRC0, 16'h0005);
    wr(`IPR_IDX_SRC0 + 10'h1, 16'h0000);
    wr(`IPR_IDX_SRC0 + 10'h5, 16'h0008);
    ext_int <= 4'h1;
    wait_acks(8'h01);
    chk(last_id, 32'h3);
    // Disabled, masked and less urgent sources must all wait.
    int_src <= '{req: 3'b011, en: 3'b001};
    ext_int <= 4'h5;
    repeat (20) @(posedge aclk);
    chk(ack_cnt, 32'h1);
    wr(`IPR_IDX_INSERV, 16'h0008);
    wait_acks(8'h02);
    chk(last_id, 32'h0);
    dly <= 4'h0;
    wr(`IPR_IDX_SRC0 + 10'h4, 16'h0001);
    ext_int <= 4'h7;
    wait_acks(8'h03);
    chk(last_id, 32'h4);
    wr(`IPR_IDX_INSERV, 16'h0011);
    repeat (20) @(posedge aclk);
    chk(ack_cnt, 32'h3);
    wr(`IPR_IDX_GATE, 16'h0001);
    wr(`IPR_IDX_SRC0 + 10'h3, 16'h0022);
    ext_int <= 4'h6;
    repeat (4) @(posedge aclk);
    ext_int <= 4'h7;
    repeat (20) @(posedge aclk);
    chk(ack_cnt, 32'h3);
    wr(`IPR_IDX_GATE, 16'h0007);
    wait_acks(8'h04);
    chk(last_id, 32'h3);
    repeat (3) @(posedge aclk);
    chk(casc_cnt, 32'h1);
    // Equal rank passes only with special nesting.
    wr(`IPR_IDX_SRC0 + 10'h4, 16'h0042);
    ext_int <= 4'h5;
    repeat (4) @(posedge aclk);
    ext_int <= 4'h7;
    wait_acks(8'h05);
    chk(last_id, 32'h4);
    // Poll mode keeps the request line low and shows the winner instead.
    wr(`IPR_IDX_INSERV, 16'h0018);
    wr(`IPR_IDX_CTRL, 16'h0001);
    ext_int <= 4'h6;
    repeat (4) @(posedge aclk);
    ext_int <= 4'h7;
    repeat (20) @(posedge aclk);
    chk(ack_cnt, 32'h5);
    rd(`IPR_IDX_POLL);
    chk(d, 32'h8003);
    wr(`IPR_IDX_CTRL, 16'h0000);
    wait_acks(8'h06);
    chk(last_id, 32'h3);
    // A held level requests without any edge.
    wr(`IPR_IDX_INSERV, 16'h0008);
    wr(`IPR_IDX_SRC0 + 10'h4, 16'h0011);
    wait_acks(8'h07);
    chk(last_id, 32'h4);
    rd(`IPR_IDX_REQST);
    chk(d, 32'h30);
    ext_int <= 4'h5;
    repeat (4) @(posedge aclk);
    wr(`IPR_IDX_INSERV, 16'h0010);
    wr(`IPR_IDX_RELOC, 16'h4000);
    rd(`IPR_IDX_RELOC);
    chk(d, 32'h4000);
    chk(slave_mode, 32'h1);
    ext_int <= 4'h0;
    repeat (4) @(posedge aclk);
    ext_int <= 4'hF;
    repeat (20) @(posedge aclk);
    chk(ack_cnt, 32'h7);
    wr(`IPR_IDX_SRC0, 16'h0025);
    int_src <= '{req: 3'b011, en: 3'b000};
    repeat (2) @(posedge aclk);
    int_src <= '{req: 3'b011, en: 3'b001};
    wait_acks(8'h08);
    repeat (3) @(posedge aclk);
    chk(last_id, 32'h0);
    chk(casc_cnt, 32'h2);
    rd(`IPR_IDX_MASK);
    chk(d, 32'h64);
    int_src <= '0;
    ext_int <= 4'h0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rst();
    tally_and_finish();
  end
endmodule : ipr_top_tb

`default_nettype wire
